// ### logic/vmsw_top.v
/*
  VME master write path with size-based swapping and width splitting,
  bus ownership handshake, Wishbone register slave and interrupt.
  Assumes all inputs synchronous to clk_i; the VME side answers each
  transfer with a one-cycle ack or bus-error pulse.
  Software owns the bus before master writes; the block does not
  check ownership before issuing them.
*/
`timescale 1ns/100ps
`include "vmsw_defs.vh"

module vmsw_top (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Local access request
  input wire req_valid_i,
  input wire [1:0] req_kind_i,
  input wire [31:0] req_addr_i,
  input wire [3:0] req_be_i,
  input wire [31:0] req_data_i,
  output reg req_ready_o,
  // VME transfer side
  output reg vme_valid_o,
  output reg vme_write_o,
  output reg [31:0] vme_addr_o,
  output reg [1:0] vme_size_o,
  output reg [3:0] vme_be_o,
  output reg [31:0] vme_data_o,
  input wire vme_ack_i,
  input wire vme_berr_i,
  output reg vme_berr_o,
  // VME bus ownership
  output reg vme_breq_o,
  input wire vme_bgrant_i,
  output reg vme_bbsy_o,
  // Interrupt
  output reg irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_WAIT = 2'h2;
  // Stall limit in clock cycles, cut to the counter width
  localparam integer STALL_CYC = `VMSW_STALL_CYC;
  localparam [9:0] STALL_LIM = STALL_CYC[9:0];

  // Software visible registers
  reg [2:0] mctl_reg;
  reg [1:0] scomm_reg;
  reg [2:0] ists_reg;
  reg [2:0] ists_next;
  reg [2:0] imsk_reg;
  reg [15:0] xcnt_reg;
  // Sequencer and current request
  reg [1:0] state_reg;
  reg [1:0] kind_reg;
  reg [31:0] base_reg;
  reg [3:0] rem_reg;
  reg [31:0] data_reg;
  reg [9:0] stall_reg;
  reg own_ack_reg;
  // Chunk decode scratch
  reg [3:0] chunk;
  reg [1:0] csize;
  reg [1:0] coff;
  reg [1:0] lim;
  reg [31:0] cdata;
  reg [31:0] rd_next;
  // Swap result and decoded strobes
  wire [31:0] sw_data;
  wire sw_en;
  wire wr_req;
  wire own_grant;
  wire xfer_ok;
  wire xfer_fail;

  //////////////////////////////////////////////////////////////////////////
  // Register write decode

  // Write lands on the edge where the master samples ack
  // Only byte lane 0 carries fields, so sel[0] gates every write
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Ownership granted while requested
  // Grant alone does nothing unless software asked for the bus
  assign own_grant = mctl_reg[`VMSW_MCTL_OWN] & vme_bgrant_i;

  // End of the current VME transfer
  // A stall at the limit counts as a failure even if ack comes late
  assign xfer_ok = (state_reg == ST_WAIT) & vme_ack_i & ~vme_berr_i;
  assign xfer_fail = (state_reg == ST_WAIT) & (vme_berr_i | (stall_reg == STALL_LIM));

  //////////////////////////////////////////////////////////////////////////
  // Chunk selection

  // Width limit: only processor writes use the programmed width
  // Merged host writes are cut back to this size, so the swap sees
  // the size software meant; other kinds keep their natural size
  always @* begin
    if (kind_reg == `VMSW_K_PWR) begin
      lim = mctl_reg[`VMSW_MCTL_WID_HI:`VMSW_MCTL_WID_LO];
    end else begin
      lim = `VMSW_SZ_LONG;
    end
  end

  // Lowest remaining lanes, no wider than the limit; natural alignment
  // No misaligned word is formed: three lanes go out as a word and a byte, or as three bytes at byte width, lowest lane first
  always @* begin
    chunk = 4'h0;
    csize = `VMSW_SZ_BYTE;
    coff = 2'h0;
    if (lim == `VMSW_SZ_LONG && rem_reg == 4'hf) begin
      chunk = 4'hf;
      csize = `VMSW_SZ_LONG;
    end else if (lim != `VMSW_SZ_BYTE && rem_reg[1:0] == 2'h3) begin
      chunk = 4'h3;
      csize = `VMSW_SZ_WORD;
    end else if (rem_reg[0]) begin
      chunk = 4'h1;
    end else if (rem_reg[1]) begin
      chunk = 4'h2;
      coff = 2'h1;
    end else if (lim != `VMSW_SZ_BYTE && rem_reg[3:2] == 2'h3) begin
      chunk = 4'hc;
      csize = `VMSW_SZ_WORD;
      coff = 2'h2;
    end else if (rem_reg[2]) begin
      chunk = 4'h4;
      coff = 2'h2;
    end else if (rem_reg[3]) begin
      chunk = 4'h8;
      coff = 2'h3;
    end
  end

  // Lanes outside the chunk are zeroed before the swap
  // Keeps bytes of merged data off lanes the chunk does not own
  always @* begin
    cdata = data_reg & {{8{chunk[3]}}, {8{chunk[2]}}, {8{chunk[1]}}, {8{chunk[0]}}};
  end

  // Master enable for local paths, slave enable for slave accesses
  // Independent enables let one direction run unswapped
  assign sw_en = (kind_reg == `VMSW_K_SLV) ? scomm_reg[`VMSW_SCOMM_SSE] :
    scomm_reg[`VMSW_SCOMM_MSE];

  vmsw_swap u_swap (
    .en_i(sw_en),
    .size_i(csize),
    .data_i(cdata),
    .data_o(sw_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  // Accept request, issue chunks one by one, abort on bus error
  // One transfer in flight; an error drops what is left, as the far
  // bus has no retry. The stall count ends a transfer never answered.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      kind_reg <= `VMSW_K_PWR;
      base_reg <= 32'h0;
      rem_reg <= 4'h0;
      data_reg <= 32'h0;
      stall_reg <= 10'h0;
      req_ready_o <= 1'b0;
      vme_valid_o <= 1'b0;
      vme_write_o <= 1'b0;
      vme_addr_o <= 32'h0;
      vme_size_o <= `VMSW_SZ_BYTE;
      vme_be_o <= 4'h0;
      vme_data_o <= 32'h0;
      vme_berr_o <= 1'b0;
      xcnt_reg <= 16'h0;
    end else begin
      vme_berr_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            kind_reg <= req_kind_i;
            base_reg <= {req_addr_i[31:2], 2'h0};
            rem_reg <= req_be_i;
            data_reg <= req_data_i;
            if (req_be_i != 4'h0) begin
              state_reg <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          vme_valid_o <= 1'b1;
          vme_write_o <= (kind_reg != `VMSW_K_PRD);
          vme_addr_o <= {base_reg[31:2], coff};
          vme_size_o <= csize;
          vme_be_o <= chunk;
          vme_data_o <= sw_data;
          rem_reg <= rem_reg & ~chunk;
          stall_reg <= 10'h0;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          stall_reg <= stall_reg + 10'h1;
          if (xfer_fail) begin
            vme_valid_o <= 1'b0;
            vme_berr_o <= 1'b1;
            rem_reg <= 4'h0;
            state_reg <= ST_IDLE;
          end else if (xfer_ok) begin
            vme_valid_o <= 1'b0;
            xcnt_reg <= xcnt_reg + 16'h1;
            if (rem_reg == 4'h0) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_LOAD;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus ownership

  // Request until granted, then hold the bus while requested
  // Busy keeps other masters off until software clears the request bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      own_ack_reg <= 1'b0;
      vme_breq_o <= 1'b0;
      vme_bbsy_o <= 1'b0;
    end else begin
      own_ack_reg <= own_grant;
      vme_breq_o <= mctl_reg[`VMSW_MCTL_OWN] & ~own_grant;
      vme_bbsy_o <= own_grant;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  // Master control and swap enables
  // Width field changes apply from the next chunk loaded
  always @(posedge clk_i) begin
    if (rst_i) begin
      mctl_reg <= `VMSW_MCTL_RST;
      scomm_reg <= `VMSW_SCOMM_RST;
      imsk_reg <= `VMSW_IMSK_RST;
    end else if (wr_req) begin
      if (wb_adr_i == `VMSW_ADDR_MCTL) begin
        mctl_reg <= wb_dat_i[2:0];
      end
      if (wb_adr_i == `VMSW_ADDR_SCOMM) begin
        scomm_reg <= wb_dat_i[1:0];
      end
      if (wb_adr_i == `VMSW_ADDR_IMSK) begin
        imsk_reg <= wb_dat_i[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status

  // Sticky events, write one to clear, set wins over clear
  // so an event that meets its own clear is not lost; ownership
  // counts only on the cycle the grant is first seen
  always @* begin
    ists_next = ists_reg;
    if (wr_req && wb_adr_i == `VMSW_ADDR_ISTS) begin
      ists_next = ists_reg & ~wb_dat_i[2:0];
    end
    if (own_grant && !own_ack_reg) begin
      ists_next[`VMSW_INT_OWN] = 1'b1;
    end
    if (xfer_fail) begin
      ists_next[`VMSW_INT_BERR] = 1'b1;
    end
    if (xfer_ok && rem_reg == 4'h0) begin
      ists_next[`VMSW_INT_DONE] = 1'b1;
    end
  end

  // Status and level interrupt
  // Interrupt follows the next status, one edge after the event
  always @(posedge clk_i) begin
    if (rst_i) begin
      ists_reg <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      ists_reg <= ists_next;
      irq_o <= |(ists_next & imsk_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone read and ack

  // Read mux; unmapped offsets read zero
  // Reads have no side effects; clearing needs an explicit write
  always @* begin
    case (wb_adr_i)
      `VMSW_ADDR_MCTL: rd_next = {29'h0, mctl_reg};
      `VMSW_ADDR_SCOMM: rd_next = {30'h0, scomm_reg};
      `VMSW_ADDR_STAT: rd_next = {29'h0, (state_reg != ST_IDLE), vme_bbsy_o, own_ack_reg};
      `VMSW_ADDR_ISTS: rd_next = {29'h0, ists_reg};
      `VMSW_ADDR_IMSK: rd_next = {29'h0, imsk_reg};
      `VMSW_ADDR_XCNT: rd_next = {16'h0, xcnt_reg};
      default: rd_next = 32'h0;
    endcase
  end

  // One-cycle ack after each request, dropped the next cycle
  // A strobe still high in the ack cycle is not answered twice
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= rd_next;
      end
    end
  end

endmodule // vmsw_top

// ### logic/vmsw_defs.vh
/*
  Constants for the VME master write swap and ownership block: register
  offsets, field positions, reset values, encodings and timing counts.
  Assumes a 50 MHz clock and a 32-bit classic Wishbone register bus.
*/
`ifndef VMSW_DEFS_VH
`define VMSW_DEFS_VH

// Register byte offsets
`define VMSW_ADDR_MCTL 6'h00
`define VMSW_ADDR_SCOMM 6'h04
`define VMSW_ADDR_STAT 6'h08
`define VMSW_ADDR_ISTS 6'h0c
`define VMSW_ADDR_IMSK 6'h10
`define VMSW_ADDR_XCNT 6'h14

// Master control fields
`define VMSW_MCTL_OWN 0
`define VMSW_MCTL_WID_LO 1
`define VMSW_MCTL_WID_HI 2
`define VMSW_MCTL_RST 3'h4

// System communication fields
`define VMSW_SCOMM_MSE 0
`define VMSW_SCOMM_SSE 1
`define VMSW_SCOMM_RST 2'h0

// Interrupt status and mask bits
`define VMSW_INT_OWN 0
`define VMSW_INT_BERR 1
`define VMSW_INT_DONE 2
`define VMSW_IMSK_RST 3'h0

// Transfer sizes
`define VMSW_SZ_BYTE 2'h0
`define VMSW_SZ_WORD 2'h1
`define VMSW_SZ_LONG 2'h2

// Request kinds
`define VMSW_K_PWR 2'h0
`define VMSW_K_PRD 2'h1
`define VMSW_K_SLV 2'h2
`define VMSW_K_DMA 2'h3

// Timing
`define VMSW_CLK_NS 20
`define VMSW_STALL_NS 20000
`define VMSW_STALL_CYC (`VMSW_STALL_NS / `VMSW_CLK_NS)

`endif

// ### logic/vmsw_swap.v
/*
  Size-based byte lane swapper for one transfer direction.
  Assumes data is already placed on its little-endian byte lanes.
*/
`timescale 1ns/100ps
`include "vmsw_defs.vh"

module vmsw_swap (
  input wire en_i,
  input wire [1:0] size_i,
  input wire [31:0] data_i,
  output reg [31:0] data_o
);

  // Select swap pattern from transfer size
  always @* begin
    data_o = data_i;
    if (en_i) begin
      case (size_i)
        `VMSW_SZ_LONG: begin
          data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
        end
        `VMSW_SZ_WORD: begin
          data_o = {data_i[23:16], data_i[31:24], data_i[7:0], data_i[15:8]};
        end
        default: begin
          data_o = data_i;
        end
      endcase
    end
  end

endmodule // vmsw_swap

// ### test/vmsw_top_asserts.sv
/* Checker for vmsw_top: lane swap, width split, ownership and errors.
   Assumes it is bound to vmsw_top and sees only its ports. */
`timescale 1ns/100ps
`include "vmsw_defs.vh"
module vmsw_top_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire req_valid_i,
  input wire [1:0] req_kind_i,
  input wire [3:0] req_be_i,
  input wire [31:0] req_data_i,
  input wire req_ready_o,
  input wire vme_valid_o,
  input wire [1:0] vme_size_o,
  input wire [3:0] vme_be_o,
  input wire [31:0] vme_data_o,
  input wire vme_berr_i,
  input wire vme_berr_o,
  input wire vme_breq_o,
  input wire vme_bgrant_i,
  input wire vme_bbsy_o,
  input wire irq_o
);
  reg [31:0] d_reg;
  reg [1:0] k_reg;
  reg [3:0] be_reg;
  reg [2:0] mctl_reg;
  reg mse_reg;
  reg msk_reg;
  // Write strobe, chunk lanes of the taken data, width cap
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire [31:0] x = d_reg & {{8{vme_be_o[3]}}, {8{vme_be_o[2]}}, {8{vme_be_o[1]}}, {8{vme_be_o[0]}}};
  wire [1:0] wcap = (mctl_reg[2:1] == 2'h3) ? `VMSW_SZ_WORD : mctl_reg[2:1];
  wire chk = vme_valid_o && (k_reg != `VMSW_K_SLV);
  // Shadows of control bits and of the request taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      mctl_reg <= `VMSW_MCTL_RST;
      mse_reg <= 1'h0;
      msk_reg <= 1'h0;
    end else begin
      if (wr && wb_adr_i == `VMSW_ADDR_MCTL) mctl_reg <= wb_dat_i[2:0];
      if (wr && wb_adr_i == `VMSW_ADDR_SCOMM) mse_reg <= wb_dat_i[`VMSW_SCOMM_MSE];
      if (wr && wb_adr_i == `VMSW_ADDR_IMSK) msk_reg <= wb_dat_i[0];
      if (req_valid_i && req_ready_o) begin
        d_reg <= req_data_i;
        k_reg <= req_kind_i;
        be_reg <= req_be_i;
      end
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence grant_s;
    mctl_reg[0] && vme_breq_o && vme_bgrant_i;
  endsequence
  long_swap_a: assert property (chk && mse_reg && vme_size_o == `VMSW_SZ_LONG |->
    vme_data_o == {x[7:0], x[15:8], x[23:16], x[31:24]}) else $error("long swap wrong");
  word_swap_a: assert property (chk && mse_reg && vme_size_o == `VMSW_SZ_WORD |->
    vme_data_o == {x[23:16], x[31:24], x[7:0], x[15:8]}) else $error("word swap wrong");
  plain_lane_a: assert property (chk && (!mse_reg || vme_size_o == `VMSW_SZ_BYTE) |->
    vme_data_o == x) else $error("lanes not passed through");
  width_cap_a: assert property (chk && k_reg == `VMSW_K_PWR |-> vme_size_o <= wcap)
    else $error("write wider than programmed");
  read_size_a: assert property (vme_valid_o && k_reg != `VMSW_K_PWR && be_reg == 4'hf |->
    vme_size_o == `VMSW_SZ_LONG) else $error("natural size lost");
  own_hold_a: assert property (grant_s |-> ##[1:2] vme_bbsy_o)
    else $error("bus not held after grant");
  own_irq_a: assert property ($rose(vme_bbsy_o) && msk_reg |-> ##[0:2] irq_o)
    else $error("no interrupt on ownership");
  berr_end_a: assert property (vme_valid_o && vme_berr_i |=> vme_berr_o && !vme_valid_o)
    else $error("bus error not ending access");
endmodule // vmsw_top_chk
bind vmsw_top vmsw_top_chk chk (.*);

// ### test/vmsw_vme_model.sv
/* VME slave and arbiter model: answers transfers, grants the bus.
   Assumes requests from vmsw_top on the same clock. */
`timescale 1ns/100ps
module vmsw_vme_model (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] dly_i,
  input wire berr_mode_i,
  input wire vme_valid_i,
  input wire vme_breq_i,
  input wire vme_bbsy_i,
  output reg vme_ack_o,
  output reg vme_berr_o,
  output reg vme_bgrant_o
);
  reg [3:0] cnt_reg;
  // Answer dly_i+1 cycles after valid rises with a one-cycle ack or error
  always @(posedge clk_i) begin
    if (rst_i || !vme_valid_i || vme_ack_o || vme_berr_o) begin
      cnt_reg <= 4'h0;
      vme_ack_o <= 1'h0;
      vme_berr_o <= 1'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      vme_ack_o <= (cnt_reg == dly_i) && !berr_mode_i;
      vme_berr_o <= (cnt_reg == dly_i) && berr_mode_i;
    end
  end
  // Grant on request, kept while the bus is held
  always @(posedge clk_i) begin
    vme_bgrant_o <= !rst_i && (vme_breq_i || (vme_bgrant_o && vme_bbsy_i));
  end
endmodule // vmsw_vme_model

// ### test/tb_vmsw_top.sv
/* Bench for vmsw_top: registers, swap, width split, ownership, errors.
   Assumes vmsw_vme_model answers on the VME side. */
`timescale 1ns/100ps
`include "vmsw_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_vmsw_top;
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg wb_cyc_i = 1'h0;
  reg wb_stb_i = 1'h0;
  reg wb_we_i = 1'h0;
  reg [5:0] wb_adr_i = 6'h0;
  reg [3:0] wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  reg req_valid_i = 1'h0;
  reg [1:0] req_kind_i = 2'h0;
  reg [31:0] req_addr_i = 32'h0;
  reg [3:0] req_be_i = 4'h0;
  reg [31:0] req_data_i = 32'h0;
  reg [3:0] ack_dly = 4'h0;
  reg berr_mode = 1'h0;
  wire [31:0] wb_dat_o, vme_data_o, vme_addr_o;
  wire vme_write_o;
  wire [1:0] vme_size_o;
  wire [3:0] vme_be_o;
  wire wb_ack_o, req_ready_o, vme_valid_o, vme_berr_o, vme_breq_o, vme_bbsy_o, irq_o;
  wire vme_ack_i, vme_berr_i, vme_bgrant_i;
  wire [2:0] mon = {vme_bbsy_o, req_ready_o, wb_ack_o};
  integer n_fail = 0;
  integer cmp_count = 0;
  integer k;
  reg [31:0] rdat;
  reg [32:0] last_aw;
  reg [37:0] x;
  reg [37:0] q[$];
  vmsw_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_kind_i(req_kind_i), .req_addr_i(req_addr_i), .req_be_i(req_be_i),
    .req_data_i(req_data_i), .req_ready_o(req_ready_o), .vme_valid_o(vme_valid_o),
    .vme_write_o(vme_write_o), .vme_addr_o(vme_addr_o), .vme_size_o(vme_size_o),
    .vme_be_o(vme_be_o),
    .vme_data_o(vme_data_o), .vme_ack_i(vme_ack_i), .vme_berr_i(vme_berr_i),
    .vme_berr_o(vme_berr_o), .vme_breq_o(vme_breq_o), .vme_bgrant_i(vme_bgrant_i),
    .vme_bbsy_o(vme_bbsy_o), .irq_o(irq_o));
  vmsw_vme_model slave (.clk_i(clk_i), .rst_i(rst_i), .dly_i(ack_dly), .berr_mode_i(berr_mode),
    .vme_valid_i(vme_valid_o), .vme_breq_i(vme_breq_o), .vme_bbsy_i(vme_bbsy_o),
    .vme_ack_o(vme_ack_i), .vme_berr_o(vme_berr_i), .vme_bgrant_o(vme_bgrant_i));
  // Clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Log each acknowledged chunk
  always @(posedge clk_i) begin
    if (vme_valid_o && vme_ack_i) begin
      q.push_back({vme_size_o, vme_be_o, vme_data_o});
      last_aw <= {vme_write_o, vme_addr_o};
    end
  end
  ////////////////////////////////////////
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Wait for a monitored flag, bounded
  task wt(input integer b);
    integer i;
    begin
      i = 0;
      @(posedge clk_i);
      while (mon[b] !== 1'h1) begin
        @(posedge clk_i);
        i++;
        if (i > 200) begin
          `CHK("wait", 1'h1, mon[b])
          end_of_test;
        end
      end
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d);
    begin
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wt(0);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
    end
  endtask
  // One local request, run to completion
  task rq(input [1:0] kd, input [3:0] b, input [31:0] d, input integer n);
    begin
      req_valid_i <= 1'h1;
      req_kind_i <= kd;
      req_be_i <= b;
      req_data_i <= d;
      wt(1);
      req_valid_i <= 1'h0;
      wt(1); // Drain before the next request
      `CHK("chunk count", n, q.size())
    end
  endtask
  task px(input [37:0] e);
    begin
      x = q.pop_front();
      `CHK("chunk", e, x)
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, `VMSW_ADDR_MCTL, 32'h0);
    `CHK("mctl", 32'h4, rdat)
    wb(1'h1, `VMSW_ADDR_SCOMM, 32'h1);
    wb(1'h0, `VMSW_ADDR_SCOMM, 32'h0);
    `CHK("scomm", 32'h1, rdat)
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 1);
    px({`VMSW_SZ_LONG, 4'hf, 32'h11223344});
    wb(1'h1, `VMSW_ADDR_MCTL, 32'h2);
    ack_dly <= 4'h3;
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 2);
    px({`VMSW_SZ_WORD, 4'h3, 32'h00001122});
    px({`VMSW_SZ_WORD, 4'hc, 32'h33440000});
    for (k = 1; k < 4; k += 2) begin
      rq(k[1:0], 4'hf, 32'h44332211, 1);
      px({`VMSW_SZ_LONG, 4'hf, 32'h11223344});
      `CHK("write", k != 1, last_aw[32])
    end
    wb(1'h1, `VMSW_ADDR_MCTL, 32'h0);
    ack_dly <= 4'h0;
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 4);
    for (k = 0; k < 4; k++) px({`VMSW_SZ_BYTE, 4'h1 << k, 32'h44332211 & (32'hff << (8 * k))});
    wb(1'h1, `VMSW_ADDR_MCTL, 32'h4);
    req_addr_i <= 32'h1003;
    rq(`VMSW_K_PWR, 4'h7, 32'h00332211, 2);
    px({`VMSW_SZ_WORD, 4'h3, 32'h00001122});
    px({`VMSW_SZ_BYTE, 4'h4, 32'h00330000});
    `CHK("lane addr", {1'h1, 32'h1002}, last_aw)
    wb(1'h1, `VMSW_ADDR_SCOMM, 32'h2);
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 1);
    px({`VMSW_SZ_LONG, 4'hf, 32'h44332211});
    rq(`VMSW_K_SLV, 4'hf, 32'h44332211, 1);
    px({`VMSW_SZ_LONG, 4'hf, 32'h11223344});
    berr_mode <= 1'h1;
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 0);
    berr_mode <= 1'h0;
    wb(1'h0, `VMSW_ADDR_ISTS, 32'h0);
    `CHK("error status", 1'h1, rdat[1])
    wb(1'h1, `VMSW_ADDR_ISTS, 32'h7);
    wb(1'h1, `VMSW_ADDR_IMSK, 32'h1);
    wb(1'h1, `VMSW_ADDR_MCTL, 32'h5);
    wt(2);
    wb(1'h0, `VMSW_ADDR_STAT, 32'h0);
    `CHK("ownership ack", 2'h3, rdat[1:0])
    `CHK("irq raised", 1'h1, irq_o)
    wb(1'h1, `VMSW_ADDR_IMSK, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'h0, irq_o)
    wb(1'h1, `VMSW_ADDR_ISTS, 32'h1);
    wb(1'h1, `VMSW_ADDR_IMSK, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'h0, irq_o)
    rq(`VMSW_K_PWR, 4'hf, 32'h44332211, 1);
    px({`VMSW_SZ_LONG, 4'hf, 32'h44332211});
    wb(1'h1, `VMSW_ADDR_MCTL, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK("bus released", 1'h0, vme_bbsy_o)
    wb(1'h0, `VMSW_ADDR_XCNT, 32'h0);
    `CHK("xcnt", 32'he, rdat)
    wb(1'h0, 6'h3c, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    end_of_test;
  end
endmodule // tb_vmsw_top
